/* File: rtl/asbp_uart.sv */
// Operation
// - tx pin serial when enabled, else GPIO
// - rx pin input only, ignored when disabled
// - baud divisor is 13 bits, 1..8191
// - bit rate is clock over 32 times divisor
// - receiver samples at sixteen times baud
// - line edges realign receiver sampling points
// - one parity enable serves both directions
// - bad received parity sets parity error flag
// - parity takes the data field's top bit
// - length and parity give 8,7+P,9,8+P bits
// - all registers accessible at any time
// - status flags clearable at any time
// - top nineteen baud register bits read zero
// - frames are ten or eleven bits long
// - parity error set with receive full flag
// - transmitter keeps pin until character ends
`timescale 1ns/1ps
`default_nettype none
module asbp_uart
    import asbp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RXD_I,
    input wire logic TXD_I,
    output logic TXD_O,
    output logic TXD_OE
);
    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    // frame length in bit times including start and stop
    function automatic logic [3:0] frame_bits(input logic lng);
        frame_bits = lng ? BITS_LONG : BITS_SHORT;
    endfunction
    // user data with parity placed in the top data bit, even parity
    function automatic logic [8:0] tx_format(input logic [8:0] w, input logic lng,
                                             input logic pe);
        tx_format = lng ? w : {1'b0, w[7:0]};
        if (pe && lng) begin
            tx_format[8] = ^w[7:0];
        end else if (pe) begin
            tx_format[7] = ^w[6:0];
        end
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [12:0] baud_div_q; // baud_divisor
    asbp_ctrl_s ctrl_q; // control bundle
    asbp_flags_s flg_q, flg_d; // receive flags
    logic [8:0] rx_data_q; // received character
    logic [13:0] bcnt_q; // baud modulus counter
    logic rx_m1_q, rx_s_q, rx_last_q; // rx synchroniser and last sample
    logic pin_m1_q, pin_s_q; // tx pin read-back synchroniser
    logic ph_valid_q, ph_write_q; // pending data phase
    logic [7:0] ph_addr_q; // its address
    logic [8:0] buf_q [0:1]; // two-entry tx buffer
    logic buf_wp_q, buf_rp_q; // buffer pointers
    logic [1:0] buf_cnt_q; // entries held
    asbp_tx_e tx_st_q; // transmitter state
    logic [3:0] tx_ph_q, tx_bit_q; // tick phase and bit index
    logic [10:0] tx_sh_q; // transmit shifter, lsb on the line
    asbp_rx_e rx_st_q; // receiver state
    logic [3:0] rx_ph_q, rx_bit_q; // tick phase and bit index
    logic [8:0] rx_sh_q; // receive shifter

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire addr_ph = HSEL && HTRANS[1] && HREADY; // address phase taken
    wire rd_ph = addr_ph && !HWRITE;
    wire [7:0] a = HADDR[7:0];
    wire wr_done = ph_valid_q && ph_write_q && HREADYOUT; // data phase ends
    wire wr_baud = wr_done && ph_addr_q == ADDR_BAUD;
    wire wr_ctrl = wr_done && ph_addr_q == ADDR_CTRL;
    wire wr_stat = wr_done && ph_addr_q == ADDR_STAT;
    wire data_wr_ph = addr_ph && HWRITE && a == ADDR_DATA; // may stall
    wire buf_in_rdy = buf_cnt_q != BUF_DEPTH; // buffer has room
    wire push = ph_valid_q && ph_write_q && !HREADYOUT && buf_in_rdy &&
                ph_addr_q == ADDR_DATA;
    wire rd_data = rd_ph && a == ADDR_DATA; // reading takes the character

    // ---------------------------------------------------------------
    // baud generator: tick at 16x baud, every 2*divisor clocks
    // ---------------------------------------------------------------
    wire div_zero = baud_div_q == BAUD_ZERO;
    wire tick = !div_zero && bcnt_q == 14'h0000;
    wire [13:0] reload = {baud_div_q, 1'b0} - 14'h0001;

    // ---------------------------------------------------------------
    // transmit side
    // ---------------------------------------------------------------
    wire buf_out_vld = buf_cnt_q != 2'h0; // buffer has a word
    wire tx_busy = tx_st_q == TX_SHIFT;
    wire tx_load = !tx_busy && ctrl_q.transmitter_en && buf_out_vld && !div_zero;
    wire tx_own = ctrl_q.transmitter_en || tx_busy;
    wire tx_bit_end = tx_busy && tick && tx_ph_q == PH_LAST;
    wire tx_last = tx_bit_q == frame_bits(ctrl_q.frame_long) - 4'h1;
    wire [8:0] tx_word = tx_format(buf_q[buf_rp_q], ctrl_q.frame_long,
                                   ctrl_q.parity_enable);
    wire [10:0] tx_frame = ctrl_q.frame_long ? {1'b1, tx_word, 1'b0}
                                             : {2'b11, tx_word[7:0], 1'b0};

    // ---------------------------------------------------------------
    // receive side
    // ---------------------------------------------------------------
    wire rx_busy = rx_st_q == RX_BUSY;
    wire rx_edge = tick && rx_s_q != rx_last_q; // transition on the line
    wire rx_start = !rx_busy && ctrl_q.receiver_en && tick && !rx_s_q;
    wire rx_smp = rx_busy && tick && rx_ph_q == PH_MID;
    wire rx_false = rx_smp && rx_bit_q == 4'h0 && rx_s_q; // start not held
    wire rx_stop = rx_smp && rx_bit_q == frame_bits(ctrl_q.frame_long) - 4'h1;
    wire rx_done = rx_stop && ctrl_q.receiver_en;
    wire [8:0] rx_word = ctrl_q.frame_long ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    wire rx_par_bad = ctrl_q.parity_enable && (^rx_word);

    // ---------------------------------------------------------------
    // flag next values: set wins over any clear
    // ---------------------------------------------------------------
    always_comb begin
        flg_d = flg_q;
        // software clears, allowed whatever the line is doing
        if (wr_stat) begin
            flg_d.perr = flg_q.perr && !HWDATA[SB_PERR];
            flg_d.ferr = flg_q.ferr && !HWDATA[SB_FERR];
            flg_d.ovr = flg_q.ovr && !HWDATA[SB_OVR];
            flg_d.full = flg_q.full && !HWDATA[SB_FULL];
        end
        // reading the character empties the holding register
        if (rd_data) begin
            flg_d.full = 1'b0;
        end
        // a finished frame sets its flags in one cycle
        if (rx_done && flg_q.full) begin
            flg_d.ovr = 1'b1;
        end else if (rx_done) begin
            flg_d.full = 1'b1;
            flg_d.perr = rx_par_bad ? 1'b1 : flg_d.perr;
            flg_d.ferr = !rx_s_q ? 1'b1 : flg_d.ferr;
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    wire [31:0] stat_word = {24'h000000, pin_s_q, rx_busy, !tx_busy && !buf_out_vld,
                             buf_in_rdy, flg_q.full, flg_q.ovr, flg_q.ferr, flg_q.perr};
    wire [31:0] ctrl_word = {26'h0000000, ctrl_q};
    wire [31:0] rd_word = (a == ADDR_BAUD) ? {19'h00000, baud_div_q} :
                          (a == ADDR_CTRL) ? ctrl_word :
                          (a == ADDR_STAT) ? stat_word :
                          (a == ADDR_DATA) ? {23'h000000, rx_data_q} : 32'h00000000;

    // ---------------------------------------------------------------
    // pin outputs: transmitter or port
    // ---------------------------------------------------------------
    wire txd_o_d = tx_own ? (tx_busy ? tx_sh_q[0] : 1'b1) : ctrl_q.gpio_out;
    wire txd_oe_d = tx_own || ctrl_q.port_dir;

    // ---------------------------------------------------------------
    // bus slave registers, answer always OKAY
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= 8'h00;
            HREADYOUT <= 1'b1;
            HRDATA <= 32'h00000000;
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            // any register, any time; data writes wait for buffer room
            if (addr_ph) begin
                ph_valid_q <= 1'b1;
                ph_write_q <= HWRITE;
                ph_addr_q <= a;
                HREADYOUT <= !data_wr_ph;
                HRDATA <= HWRITE ? 32'h00000000 : rd_word;
            end else if (HREADYOUT) begin
                ph_valid_q <= 1'b0;
            end else if (push) begin
                HREADYOUT <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // software registers and flags
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            baud_div_q <= BAUD_RST;
            ctrl_q <= '0;
            flg_q <= '0;
            rx_data_q <= 9'h000;
        end else begin
            if (wr_baud) begin
                baud_div_q <= HWDATA[BAUD_W-1:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= HWDATA[CB_GOUT:CB_TE];
            end
            flg_q <= flg_d;
            // overrun keeps the older character
            if (rx_done && !flg_q.full) begin
                rx_data_q <= rx_word;
            end
        end
    end

    // ---------------------------------------------------------------
    // baud counter and pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            bcnt_q <= 14'h0000;
            rx_m1_q <= 1'b1;
            rx_s_q <= 1'b1;
            pin_m1_q <= 1'b0;
            pin_s_q <= 1'b0;
        end else begin
            bcnt_q <= div_zero ? 14'h0000 : (bcnt_q == 14'h0000 ? reload : bcnt_q - 14'h0001);
            rx_m1_q <= RXD_I;
            rx_s_q <= rx_m1_q;
            pin_m1_q <= TXD_I;
            pin_s_q <= pin_m1_q;
        end
    end

    // ---------------------------------------------------------------
    // tx buffer: filled by the bus, drained by the transmitter
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (push) begin
                buf_q[buf_wp_q] <= HWDATA[DATA_W-1:0];
                buf_wp_q <= !buf_wp_q;
            end
            if (tx_load) begin
                buf_rp_q <= !buf_rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, tx_load};
        end
    end

    // ---------------------------------------------------------------
    // transmitter: runs the character out even if disabled meanwhile
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_st_q <= TX_IDLE;
            tx_ph_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= '1;
            TXD_O <= 1'b1;
            TXD_OE <= 1'b0;
        end else begin
            TXD_O <= txd_o_d;
            TXD_OE <= txd_oe_d;
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_st_q <= TX_SHIFT;
                        tx_sh_q <= tx_frame;
                        tx_ph_q <= 4'h0;
                        tx_bit_q <= 4'h0;
                    end
                end
                TX_SHIFT: begin
                    tx_ph_q <= tick ? tx_ph_q + 4'h1 : tx_ph_q;
                    // each bit lasts sixteen ticks
                    if (tx_bit_end) begin
                        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        tx_st_q <= tx_last ? TX_IDLE : TX_SHIFT;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // receiver: sample mid-bit, resync phase on every line edge
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_st_q <= RX_IDLE;
            rx_ph_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_last_q <= 1'b1;
        end else begin
            if (tick) begin
                rx_last_q <= rx_s_q;
            end
            case (rx_st_q)
                RX_IDLE: begin
                    if (rx_start) begin
                        rx_st_q <= RX_BUSY;
                        rx_ph_q <= PH_RESYNC;
                        rx_bit_q <= 4'h0;
                    end
                end
                RX_BUSY: begin
                    // an edge marks a bit start: sample points follow it
                    if (rx_edge) begin
                        rx_ph_q <= PH_RESYNC;
                    end else if (tick) begin
                        rx_ph_q <= rx_ph_q + 4'h1;
                    end
                    if (rx_smp) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        rx_sh_q <= (rx_bit_q == 4'h0) ? rx_sh_q : {rx_s_q, rx_sh_q[8:1]};
                    end
                    // disabled receiver drops the frame
                    if (!ctrl_q.receiver_en || rx_false || rx_stop) begin
                        rx_st_q <= RX_IDLE;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_start_bit;
        ##1 !TXD_O ##0 TXD_OE;
    endsequence
    sequence s_tick_gap;
        !tick ##1 tick;
    endsequence
    property p_baud_zero;
        div_zero |-> !tick;
    endproperty
    a_baud_zero: assert property (p_baud_zero) else $error("tick with zero divisor");
    property p_tick_period;
        tick && baud_div_q == 13'h0001 && !wr_baud |=> s_tick_gap;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
    property p_tx_start;
        tx_load |=> s_start_bit;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit not driven");
    property p_tx_keep;
        tx_busy |=> TXD_OE;
    endproperty
    a_tx_keep: assert property (p_tx_keep) else $error("pin released mid char");
    property p_rx_off;
        !ctrl_q.receiver_en && !rx_busy |=> !rx_busy;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("disabled receiver started");
    property p_perr_full;
        $rose(flg_q.perr) |-> $rose(flg_q.full);
    endproperty
    a_perr_full: assert property (p_perr_full) else $error("parity flag alone");
    property p_no_parity;
        rx_done && !ctrl_q.parity_enable && !flg_q.perr |=> !flg_q.perr;
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("parity flag unused");
    property p_tx_par;
        tx_load && ctrl_q.parity_enable && !ctrl_q.frame_long |=> !(^tx_sh_q[8:1]);
    endproperty
    a_tx_par: assert property (p_tx_par) else $error("tx parity wrong");
    property p_baud_top;
        rd_ph && a == ADDR_BAUD |=> HRDATA[31:13] == 19'h00000;
    endproperty
    a_baud_top: assert property (p_baud_top) else $error("baud top bits set");
    property p_resync;
        rx_busy && rx_edge && !rx_stop && !rx_false && ctrl_q.receiver_en
            |=> rx_ph_q == PH_RESYNC;
    endproperty
    a_resync: assert property (p_resync) else $error("no realign on edge");
endmodule
`default_nettype wire

/* File: rtl/asbp_pkg.sv */
// ---------------------------------------------------------------
// shared constants and types of the serial port
// ---------------------------------------------------------------
package asbp_pkg;
    // register byte offsets, low address byte only
    localparam logic [7:0] ADDR_BAUD = 8'h00; // baud divisor word
    localparam logic [7:0] ADDR_CTRL = 8'h04; // enables and frame format
    localparam logic [7:0] ADDR_STAT = 8'h08; // flags, write one to clear
    localparam logic [7:0] ADDR_DATA = 8'h0C; // tx push, rx read
    // baud divisor field
    localparam int BAUD_W = 13;
    localparam logic [12:0] BAUD_RST = 13'h0004;
    localparam logic [12:0] BAUD_ZERO = 13'h0000;
    // control word bit positions
    localparam int CB_TE = 0;
    localparam int CB_RE = 1;
    localparam int CB_PE = 2;
    localparam int CB_LONG = 3;
    localparam int CB_DIR = 4;
    localparam int CB_GOUT = 5;
    // status word bit positions
    localparam int SB_PERR = 0;
    localparam int SB_FERR = 1;
    localparam int SB_OVR = 2;
    localparam int SB_FULL = 3;
    localparam int SB_TXRDY = 4;
    localparam int SB_TXIDLE = 5;
    localparam int SB_RXACT = 6;
    localparam int SB_PIN = 7;
    // character and frame geometry
    localparam int DATA_W = 9;
    localparam logic [3:0] BITS_SHORT = 4'hA; // start, 8 data, stop
    localparam logic [3:0] BITS_LONG = 4'hB; // start, 9 data, stop
    localparam logic [3:0] PH_MID = 4'h8; // sample point in a bit
    localparam logic [3:0] PH_LAST = 4'hF; // last of 16 ticks
    localparam logic [3:0] PH_RESYNC = 4'h1; // phase after an edge
    localparam logic [1:0] BUF_DEPTH = 2'h2; // tx buffer entries
    // control bits as one bundle
    typedef struct packed {
        logic gpio_out; // level on the tx pin as port output
        logic port_dir; // port_direction_register bit, 1 drives
        logic frame_long; // nine-bit character
        logic parity_enable; // parity on both directions
        logic receiver_en; // receiver on
        logic transmitter_en; // transmitter_enable
    } asbp_ctrl_s;
    // receive error and full flags
    typedef struct packed {
        logic full; // receive_full_flag
        logic ovr; // word lost, holding register busy
        logic ferr; // stop bit read low
        logic perr; // parity_error_flag
    } asbp_flags_s;
    typedef enum logic {TX_IDLE, TX_SHIFT} asbp_tx_e;
    typedef enum logic {RX_IDLE, RX_BUSY} asbp_rx_e;
endpackage

/* File: test/asbp_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// serial device on the far side of the pins
// ------
module asbp_line_model #(
    parameter int BIT = 32 // clocks per bit at divisor 1
) (
    input wire logic clk,
    input wire logic txd, // resolved tx pin level
    output logic rxd // drives the receive pin
);
    int nbits = 8; // data bits per captured frame
    logic [8:0] got_q[$]; // characters seen on the tx pin
    initial rxd = 1'b1;
    // one frame: start low, data lsb first, stop high
    task automatic send(input logic [8:0] d, input int n, input int per);
        rxd <= 1'b0;
        repeat (per) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= d[i];
            repeat (per) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (per) @(posedge clk);
    endtask
    // capture on the tx pin, sampling mid-bit
    always begin
        logic [8:0] d;
        @(negedge txd);
        d = '0;
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(negedge clk);
            d[i] = txd;
        end
        repeat (BIT) @(negedge clk);
        // a low stop bit spoils the character
        if (txd !== 1'b1) d = 'x;
        got_q.push_back(d);
    end
endmodule
`default_nettype wire

/* File: test/asbp_uart_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module asbp_uart_tb
    import asbp_pkg::*;
;
    // ------
    // bench signals
    // ------
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0; // clock, reset, bus
    logic [1:0] htrans = 2'h0; // transfer type
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd; // bus words
    logic hreadyout, hresp, rxd, txd_o, txd_oe; // design outputs, rx pin
    wire logic txd_w; // tx pin with its pull-up
    logic [8:0] c; // character sent to the receiver
    logic resp; // response seen in the data phase
    int miscompares = 0, comparisons = 0;
    longint t0; // start of the stalled write
    assign txd_w = txd_oe ? txd_o : 1'b1;
    always #5 clk = ~clk;
    asbp_uart u_dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RXD_I(rxd),
        .TXD_I(txd_w), .TXD_O(txd_o), .TXD_OE(txd_oe));
    asbp_line_model u_line (.clk(clk), .txd(txd_w), .rxd(rxd));
    // ------
    // tasks
    // ------
    // one single transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] q);
        logic r;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin @(negedge clk); r = hreadyout; @(posedge clk); end while (r !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge clk);
            r = hreadyout;
            q = hrdata;
            resp = hresp;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        cmp(rd, exp);
        cmp({31'h0, resp}, 32'h0);
    endtask
    // wait for the device to capture one frame, then let the stop bit end
    task automatic txchk(input logic [8:0] exp);
        int n = 0;
        while (u_line.got_q.size() == 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        // no frame within the limit counts as a mismatch
        if (n >= 3000) miscompares++;
        cmp({23'h0, u_line.got_q.pop_front()}, {23'h0, exp});
        repeat (32) @(posedge clk);
    endtask
    // character on the line per mode: bit0 parity, bit1 long frame
    function automatic logic [8:0] fmt(input int m, input logic [8:0] d);
        case (m)
            0: return {1'b0, d[7:0]};
            1: return {1'b0, ^d[6:0], d[6:0]};
            2: return d;
            default: return {^d[7:0], d[7:0]};
        endcase
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ------
    // tests
    // ------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(ADDR_BAUD, 32'h4);
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_STAT, 32'hB0);
        wr(ADDR_BAUD, 32'hFFFF_FFFF);
        rchk(ADDR_BAUD, 32'h1FFF);
        rchk(8'h10, 32'h0);
        // zero divisor: word waits in the buffer, line idle
        wr(ADDR_BAUD, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_DATA, 32'h5A);
        repeat (300) @(posedge clk);
        rchk(ADDR_STAT, 32'h90);
        wr(ADDR_BAUD, 32'h1);
        txchk(9'h05A);
        // every length and parity mode, both directions
        for (int m = 0; m < 4; m++) begin
            u_line.nbits = m[1] ? 9 : 8;
            wr(ADDR_CTRL, 32'h3 | (m << 2));
            wr(ADDR_DATA, 32'h025);
            txchk(fmt(m, 9'h025));
            // odd modes get a wrong parity bit, mode 2 a fast sender
            c = fmt(m, 9'h155) ^ (m[0] ? (m[1] ? 9'h100 : 9'h080) : 9'h0);
            u_line.send(c, m[1] ? 9 : 8, m == 2 ? 30 : 32);
            bus(1'b0, ADDR_STAT, 32'h0, rd);
            cmp(rd & 32'hF, 32'h8 | m[0]);
            rchk(ADDR_DATA, {23'h0, c});
            wr(ADDR_STAT, 32'hF);
            bus(1'b0, ADDR_STAT, 32'h0, rd);
            cmp(rd & 32'hF, 32'h0);
        end
        // stop bit low, then a second frame before the read: framing and overrun
        wr(ADDR_CTRL, 32'h3);
        u_line.send(9'h0AA, 9, 32);
        u_line.send(9'h055, 8, 32);
        bus(1'b0, ADDR_STAT, 32'h0, rd);
        cmp(rd & 32'hF, 32'hE);
        rchk(ADDR_DATA, 32'h0AA);
        wr(ADDR_STAT, 32'hF);
        // receiver off: frame ignored
        u_line.nbits = 8;
        wr(ADDR_CTRL, 32'h1);
        u_line.send(9'h0F, 8, 32);
        rchk(ADDR_STAT, 32'hB0);
        // transmitter switched off mid-character
        wr(ADDR_DATA, 32'h0C3);
        repeat (100) @(posedge clk);
        wr(ADDR_CTRL, 32'h0);
        cmp({31'h0, txd_oe}, 32'h1);
        txchk(9'h0C3);
        cmp({31'h0, txd_oe}, 32'h0);
        // fill shifter and buffer, fourth write stalls
        wr(ADDR_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            t0 = $time;
            wr(ADDR_DATA, 32'h30 + i);
        end
        cmp({31'h0, ($time - t0) > 200}, 32'h1);
        for (int i = 0; i < 4; i++) txchk(9'(48 + i));
        rchk(ADDR_STAT, 32'hB0);
        // port mode drives the pin low
        wr(ADDR_CTRL, 32'h10);
        repeat (4) @(posedge clk);
        cmp({30'h0, txd_oe, txd_o}, 32'h2);
        rchk(ADDR_STAT, 32'h30);
        give_verdict;
    end
    // watchdog for a hung handshake
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
endmodule
`default_nettype wire
